// ### pcfg_pkg.sv
package pcfg_pkg;
	localparam int PCFG_DATA_W = 8;
	localparam int PCFG_FIFO_DEPTH = 8;
	localparam int PCFG_PAGE_W = 3;
	localparam int PCFG_PAGE_COUNT = 8;
	localparam int PCFG_SYNC_W = 5 + PCFG_PAGE_W + PCFG_DATA_W;
	// bit positions inside the synchronised pin vector
	localparam int PCFG_POS_DATA = 0;
	localparam int PCFG_POS_PAGE = PCFG_POS_DATA + PCFG_DATA_W;
	localparam int PCFG_POS_UPD = PCFG_POS_PAGE + PCFG_PAGE_W;
	localparam int PCFG_POS_RS_N = PCFG_POS_UPD + 1;
	localparam int PCFG_POS_WS_N = PCFG_POS_RS_N + 1;
	localparam int PCFG_POS_CS_HI = PCFG_POS_WS_N + 1;
	localparam int PCFG_POS_CS_LO_N = PCFG_POS_CS_HI + 1;
	localparam int PCFG_TOP_BIT = PCFG_DATA_W - 1;
	// reset values
	localparam logic PCFG_RDY_RST = 1'b1;
	localparam logic PCFG_OE_N_RST = 1'b1;
	// selects, write and read strobe all idle: low-select high, high-select low, strobes high
	localparam logic [PCFG_SYNC_W-1:0] PCFG_SYNC_RST = {4'hB, {(PCFG_SYNC_W-4){1'b0}}};
	localparam logic [PCFG_PAGE_W-1:0] PCFG_PAGE_RST = 3'h0;
	localparam logic [PCFG_DATA_W-1:0] PCFG_BYTE_RST = 8'h00;

	typedef enum logic [1:0] {
		PCFG_ST_PRECFG,
		PCFG_ST_LOAD,
		PCFG_ST_INIT,
		PCFG_ST_USER
	} pcfg_state_t;
endpackage

// ### pcfg_stream_if.sv
`timescale 1ns/100ps
interface pcfg_stream_if #(
	parameter int WIDTH = 8
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### pcfg_fifo.sv
`timescale 1ns/100ps
module pcfg_fifo import pcfg_pkg::*; #(
	parameter int WIDTH = PCFG_DATA_W,
	parameter int DEPTH = PCFG_FIFO_DEPTH
) (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	pcfg_stream_if.snk fill, // filling side
	pcfg_stream_if.src drain // draining side
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic do_wr;
	logic do_rd;

	assign fill.ready = (cnt_q != FULL_CNT);
	assign drain.valid = (cnt_q != '0);
	assign drain.data = mem_q[rd_q];
	assign do_wr = fill.valid && fill.ready;
	assign do_rd = drain.valid && drain.ready;

	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem_q[wr_q] <= fill.data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (do_wr) begin
				wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
			end
			if (do_rd) begin
				rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (do_wr && !do_rd) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (do_rd && !do_wr) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ### pcfg_handshake.sv
// Behaviour
// - read strobe low drives ready/busy on top line
// - ready high accepts byte, low when busy
// - ready high before load and until user mode
// - selected only with low-select low, high-select high
// - update source high remote, low local
// - page lines pick one of eight pages
// - other schemes leave these pins tri-stated
// - after configuration pins follow user settings
// - byte latched on write strobe rising edge
`timescale 1ns/100ps
module pcfg_handshake import pcfg_pkg::*; #(
	parameter int FIFO_DEPTH = PCFG_FIFO_DEPTH
) (
	input wire logic clock, // 50 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic scheme_ppa, // parallel async scheme chosen
	input wire logic load_start, // core begins taking configuration
	input wire logic load_done, // core has all configuration data
	input wire logic init_done, // initialization finished, enter user mode
	input wire logic remote_cfg_en, // remote configuration mode active
	input wire logic chip_select_low_active, // pin, active low select
	input wire logic chip_select_high_active, // pin, active high select
	input wire logic write_strobe_n, // pin, byte latched on rising edge
	input wire logic read_strobe_n, // pin, low requests status
	input wire logic [PCFG_DATA_W-1:0] data_in, // data pins, input side
	input wire logic update_source_select, // pin, high remote, low local
	input wire logic [PCFG_PAGE_W-1:0] page_select, // pin, memory page
	input wire logic user_top_out, // user value for top data line
	input wire logic user_top_oe_n, // user enable for top data line
	input wire logic user_rdy_out, // user value for ready pin
	input wire logic user_rdy_oe_n, // user enable for ready pin
	input wire logic cfg_byte_ready, // core takes a byte
	output logic cfg_byte_valid, // byte waiting for the core
	output logic [PCFG_DATA_W-1:0] cfg_byte, // configuration byte
	output logic top_data_out, // top data line value
	output logic top_data_oe_n, // top data line enable, low drives
	output logic ready_busy_flag, // ready pin value
	output logic ready_busy_oe_n, // ready pin enable, low drives
	output logic selected, // device selected for configuration
	output logic overrun, // byte written while busy, sticky
	output logic remote_update, // remote update chosen
	output logic [PCFG_PAGE_W-1:0] mem_page, // page of external memory
	output logic user_mode // block released pins to user logic
);
	pcfg_state_t state_q;
	logic [PCFG_SYNC_W-1:0] meta_q;
	logic [PCFG_SYNC_W-1:0] sync_q;
	logic ws_prev_q;
	logic push_q;
	logic [PCFG_DATA_W-1:0] push_data_q;
	logic byte_valid_q;
	logic [PCFG_DATA_W-1:0] byte_q;
	logic top_q;
	logic top_oe_n_q;
	logic rdy_q;
	logic rdy_oe_n_q;
	logic sel_q;
	logic overrun_q;
	logic remote_q;
	logic [PCFG_PAGE_W-1:0] page_q;
	logic user_q;
	logic sel_now;
	logic ws_rise;
	logic take_byte;
	logic can_take;
	logic rdy_d;

	pcfg_stream_if #(.WIDTH(PCFG_DATA_W)) to_fifo ();
	pcfg_stream_if #(.WIDTH(PCFG_DATA_W)) from_fifo ();

	pcfg_fifo #(
		.WIDTH(PCFG_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.fill(to_fifo.snk),
		.drain(from_fifo.src)
	);

	// all pins are asynchronous to this clock
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= PCFG_SYNC_RST;
			sync_q <= PCFG_SYNC_RST;
		end else begin
			meta_q <= {chip_select_low_active, chip_select_high_active, write_strobe_n,
				read_strobe_n, update_source_select, page_select, data_in};
			sync_q <= meta_q;
		end
	end

	assign sel_now = !sync_q[PCFG_POS_CS_LO_N] && sync_q[PCFG_POS_CS_HI];
	// data travels through the same two stages as the strobe, so it is aligned
	assign ws_rise = sync_q[PCFG_POS_WS_N] && !ws_prev_q;
	assign take_byte = ws_rise && sel_now && scheme_ppa && (state_q == PCFG_ST_LOAD);
	assign can_take = !push_q && to_fifo.ready;

	always_ff @(posedge clock) begin
		if (rst) begin
			ws_prev_q <= 1'b1;
		end else begin
			ws_prev_q <= sync_q[PCFG_POS_WS_N];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= PCFG_ST_PRECFG;
		end else begin
			unique case (state_q)
				PCFG_ST_PRECFG: begin
					if (load_start) begin
						state_q <= PCFG_ST_LOAD;
					end
				end
				PCFG_ST_LOAD: begin
					// wait for buffered bytes so none is lost at the hand-off
					if (load_done && !push_q && !from_fifo.valid && !byte_valid_q) begin
						state_q <= PCFG_ST_INIT;
					end
				end
				PCFG_ST_INIT: begin
					if (init_done) begin
						state_q <= PCFG_ST_USER;
					end
				end
				PCFG_ST_USER: begin
					state_q <= PCFG_ST_USER;
				end
			endcase
		end
	end

	// flag mirrors the user state from a flip-flop, not a decode
	always_ff @(posedge clock) begin
		if (rst) begin
			user_q <= 1'b0;
		end else begin
			user_q <= (state_q == PCFG_ST_USER) || ((state_q == PCFG_ST_INIT) && init_done);
		end
	end

	// one-entry holding stage ahead of the buffer
	always_ff @(posedge clock) begin
		if (rst) begin
			push_q <= 1'b0;
			push_data_q <= PCFG_BYTE_RST;
		end else if (take_byte && can_take) begin
			push_q <= 1'b1;
			push_data_q <= sync_q[PCFG_POS_DATA +: PCFG_DATA_W];
		end else if (push_q && to_fifo.ready) begin
			push_q <= 1'b0;
		end
	end

	assign to_fifo.valid = push_q;
	assign to_fifo.data = push_data_q;

	// a write while busy is dropped; the host broke the polling discipline
	always_ff @(posedge clock) begin
		if (rst) begin
			overrun_q <= 1'b0;
		end else if (take_byte && !can_take) begin
			overrun_q <= 1'b1;
		end
	end

	// output stage keeps the core-side byte on a flip-flop
	assign from_fifo.ready = !byte_valid_q || cfg_byte_ready;

	always_ff @(posedge clock) begin
		if (rst) begin
			byte_valid_q <= 1'b0;
			byte_q <= PCFG_BYTE_RST;
		end else if (from_fifo.ready) begin
			byte_valid_q <= from_fifo.valid;
			if (from_fifo.valid) begin
				byte_q <= from_fifo.data;
			end
		end
	end

	always_comb begin
		rdy_d = PCFG_RDY_RST;
		if (state_q == PCFG_ST_LOAD) begin
			// busy while a byte is being stored or the buffer is full
			rdy_d = !(take_byte || push_q) && to_fifo.ready;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdy_q <= PCFG_RDY_RST;
			rdy_oe_n_q <= PCFG_OE_N_RST;
		end else if (state_q == PCFG_ST_USER) begin
			rdy_q <= user_rdy_out;
			rdy_oe_n_q <= user_rdy_oe_n;
		end else if (scheme_ppa) begin
			rdy_q <= rdy_d;
			rdy_oe_n_q <= 1'b0;
		end else begin
			rdy_q <= PCFG_RDY_RST;
			rdy_oe_n_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			top_q <= PCFG_RDY_RST;
			top_oe_n_q <= PCFG_OE_N_RST;
		end else if (state_q == PCFG_ST_USER) begin
			top_q <= user_top_out;
			top_oe_n_q <= user_top_oe_n;
		end else if (scheme_ppa && !sync_q[PCFG_POS_RS_N]) begin
			top_q <= rdy_d;
			top_oe_n_q <= 1'b0;
		end else begin
			top_q <= PCFG_RDY_RST;
			top_oe_n_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= sel_now && scheme_ppa && (state_q != PCFG_ST_USER);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			remote_q <= 1'b0;
			page_q <= PCFG_PAGE_RST;
		end else if (remote_cfg_en && (state_q != PCFG_ST_USER)) begin
			remote_q <= sync_q[PCFG_POS_UPD];
			page_q <= sync_q[PCFG_POS_PAGE +: PCFG_PAGE_W];
		end
	end

	assign cfg_byte_valid = byte_valid_q;
	assign cfg_byte = byte_q;
	assign top_data_out = top_q;
	assign top_data_oe_n = top_oe_n_q;
	assign ready_busy_flag = rdy_q;
	assign ready_busy_oe_n = rdy_oe_n_q;
	assign selected = sel_q;
	assign overrun = overrun_q;
	assign remote_update = remote_q;
	assign mem_page = page_q;
	assign user_mode = user_q;
endmodule

// ### pcfg_sva.sv
`timescale 1ns/100ps
module pcfg_sva import pcfg_pkg::*; (
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire logic scheme_ppa, // scheme
	input wire logic remote_cfg_en, // remote mode
	input wire logic chip_select_low_active, // pin
	input wire logic chip_select_high_active, // pin
	input wire logic write_strobe_n, // pin
	input wire logic read_strobe_n, // pin
	input wire logic update_source_select, // pin
	input wire logic [PCFG_PAGE_W-1:0] page_select, // pin
	input wire logic user_rdy_out, // user value
	input wire logic user_rdy_oe_n, // user enable
	input wire logic top_data_out, // line value
	input wire logic top_data_oe_n, // line enable
	input wire logic ready_busy_flag, // ready value
	input wire logic ready_busy_oe_n, // ready enable
	input wire logic selected, // selected
	input wire logic remote_update, // remote chosen
	input wire logic [PCFG_PAGE_W-1:0] mem_page, // page
	input wire logic user_mode // user state
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// four samples cover the 2-flop synchroniser plus the output register
	sequence status_req;
		(!read_strobe_n && scheme_ppa && !user_mode)[*4];
	endsequence
	sequence remote_steady;
		(remote_cfg_en && !user_mode)[*4];
	endsequence
	status_drive_a: assert property (status_req ##0 $stable(ready_busy_flag) |->
		!top_data_oe_n && top_data_out == ready_busy_flag) else $error("status line not driven");
	busy_cause_a: assert property ($fell(ready_busy_flag) && scheme_ppa && !user_mode |->
		$past(write_strobe_n, 3) && !$past(write_strobe_n, 4)) else $error("busy without strobe");
	select_on_a: assert property ((!chip_select_low_active && chip_select_high_active
		&& scheme_ppa && !user_mode)[*5] |-> selected) else $error("not selected");
	select_off_a: assert property ((chip_select_low_active || !chip_select_high_active)[*5]
		|-> !selected) else $error("selected while deselected");
	other_scheme_a: assert property ((!scheme_ppa && !user_mode)[*2] |->
		top_data_oe_n && ready_busy_oe_n) else $error("pins driven in other scheme");
	user_copy_a: assert property (user_mode && $past(user_mode) |->
		ready_busy_flag == $past(user_rdy_out) && ready_busy_oe_n == $past(user_rdy_oe_n))
		else $error("ready pin not user owned");
	remote_src_a: assert property (remote_steady |->
		remote_update == $past(update_source_select, 3)) else $error("update source wrong");
	page_pick_a: assert property (remote_steady |->
		mem_page == $past(page_select, 3)) else $error("page wrong");
endmodule
bind pcfg_handshake pcfg_sva i_pcfg_sva (.clock, .rst, .scheme_ppa, .remote_cfg_en,
	.chip_select_low_active, .chip_select_high_active, .write_strobe_n, .read_strobe_n,
	.update_source_select, .page_select, .user_rdy_out, .user_rdy_oe_n, .top_data_out,
	.top_data_oe_n, .ready_busy_flag, .ready_busy_oe_n, .selected, .remote_update, .mem_page,
	.user_mode);

// ### pcfg_host.sv
`timescale 1ns/100ps
module pcfg_host (
	input wire logic clock, // system clock
	input wire logic top_data_out, // status line value
	input wire logic top_data_oe_n, // status line enable, low drives
	output logic chip_select_low_active = 1'b0,
	output logic chip_select_high_active = 1'b1,
	output logic write_strobe_n = 1'b1, // write strobe
	output logic read_strobe_n = 1'b1,
	output logic [7:0] data_in = 8'h00 // data pins
);
	// 4-cycle phases stay clear of the 3-stage input path
	task automatic strobe(input logic [7:0] b);
		@(posedge clock) #1 data_in = b;
		write_strobe_n = 1'b0;
		repeat (4) @(posedge clock);
		#1 write_strobe_n = 1'b1;
		repeat (4) @(posedge clock);
		#1 data_in = ~b;
	endtask
	// gives up after 40 cycles so a stuck busy cannot hang the host
	task automatic poll(output bit ok);
		@(posedge clock) #1 read_strobe_n = 1'b0;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(posedge clock) #1;
			ok = top_data_oe_n === 1'b0 && top_data_out === 1'b1;
		end
		read_strobe_n = 1'b1;
	endtask
endmodule

// ### pcfg_handshake_bench.sv
`timescale 1ns/100ps
module pcfg_handshake_bench;
	typedef struct {logic [7:0] b; logic [2:0] pg; logic up;} pcfg_row_t;
	logic clock = 1'b0, rst = 1'b1, scheme_ppa = 1'b1, load_start = 1'b0, load_done = 1'b0;
	logic init_done = 1'b0, remote_cfg_en = 1'b1, update_source_select = 1'b0;
	logic user_top_out = 1'b0, user_top_oe_n = 1'b1, user_rdy_out = 1'b1, user_rdy_oe_n = 1'b1;
	logic cfg_byte_ready = 1'b0;
	logic [2:0] page_select = 3'h0;
	logic chip_select_low_active, chip_select_high_active, write_strobe_n, read_strobe_n;
	logic cfg_byte_valid, top_data_out, top_data_oe_n, ready_busy_flag, ready_busy_oe_n;
	logic selected, overrun, remote_update, user_mode;
	logic [7:0] data_in, cfg_byte;
	logic [2:0] mem_page;
	int err_total = 0, checks = 0;
	bit ok;
	pcfg_row_t rows[8] = '{'{8'h00, 3'h0, 1'b0}, '{8'hFF, 3'h1, 1'b1}, '{8'hA5, 3'h2, 1'b0},
		'{8'h5A, 3'h3, 1'b1}, '{8'h01, 3'h4, 1'b0}, '{8'h80, 3'h5, 1'b1},
		'{8'h7E, 3'h6, 1'b0}, '{8'h3C, 3'h7, 1'b1}};
	pcfg_handshake i_pcfg_handshake (.clock, .rst, .scheme_ppa, .load_start, .load_done,
		.init_done, .remote_cfg_en, .chip_select_low_active, .chip_select_high_active,
		.write_strobe_n, .read_strobe_n, .data_in, .update_source_select, .page_select,
		.user_top_out, .user_top_oe_n, .user_rdy_out, .user_rdy_oe_n, .cfg_byte_ready,
		.cfg_byte_valid, .cfg_byte, .top_data_out, .top_data_oe_n, .ready_busy_flag,
		.ready_busy_oe_n, .selected, .overrun, .remote_update, .mem_page, .user_mode);
	pcfg_host i_pcfg_host (.clock, .top_data_out, .top_data_oe_n, .chip_select_low_active,
		.chip_select_high_active, .write_strobe_n, .read_strobe_n, .data_in);
	always #10 clock = ~clock;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic take(input logic [7:0] exp);
		int n;
		n = 0;
		while (cfg_byte_valid !== 1'b1 && n < 30) begin
			@(posedge clock) #1;
			n++;
		end
		check(cfg_byte, exp);
		cfg_byte_ready = 1'b1;
		@(posedge clock) #1 cfg_byte_ready = 1'b0;
		@(posedge clock) #1;
	endtask
	task automatic complete_run;
		$display("checks=%0d errors=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		i_pcfg_host.poll(ok);
		check(8'(ok), 8'h01);
		check(8'(ready_busy_oe_n), 8'h00);
		check(8'(selected), 8'h01);
		load_start = 1'b1;
		for (int i = 0; i < 8; i++) begin
			page_select = rows[i].pg;
			update_source_select = rows[i].up;
			i_pcfg_host.poll(ok);
			check(8'(ok), 8'h01);
			i_pcfg_host.strobe(rows[i].b);
			take(rows[i].b);
			check(8'(mem_page), 8'(rows[i].pg));
			check(8'(remote_update), 8'(rows[i].up));
		end
		// core stalls: output stage plus 8 fifo words fill before busy holds
		for (int i = 0; i < 9; i++) begin
			i_pcfg_host.poll(ok);
			check(8'(ok), 8'h01);
			i_pcfg_host.strobe(8'(i + 16));
		end
		i_pcfg_host.poll(ok);
		check(8'(ok), 8'h00);
		i_pcfg_host.strobe(8'hEE);
		check(8'(overrun), 8'h01);
		for (int i = 0; i < 9; i++)
			take(8'(i + 16));
		i_pcfg_host.poll(ok);
		check(8'(ok), 8'h01);
		i_pcfg_host.chip_select_high_active = 1'b0;
		i_pcfg_host.strobe(8'h11);
		repeat (8) @(posedge clock);
		#1 check(8'(cfg_byte_valid), 8'h00);
		check(8'(selected), 8'h00);
		i_pcfg_host.chip_select_high_active = 1'b1;
		scheme_ppa = 1'b0;
		i_pcfg_host.poll(ok);
		check({6'h00, top_data_oe_n, ready_busy_oe_n}, 8'h03);
		scheme_ppa = 1'b1;
		load_done = 1'b1;
		repeat (6) @(posedge clock);
		i_pcfg_host.poll(ok);
		check(8'(ok), 8'h01);
		init_done = 1'b1;
		user_rdy_out = 1'b0;
		user_rdy_oe_n = 1'b0;
		user_top_out = 1'b1;
		user_top_oe_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 check({5'h00, user_mode, ready_busy_flag, ready_busy_oe_n}, 8'h04);
		check({6'h00, top_data_out, top_data_oe_n}, 8'h02);
		complete_run;
	end
endmodule
